// ---- verilog/pfp_consts.vh ----
// constants of the parallel flash programming port
`ifndef PFP_CONSTS_VH
`define PFP_CONSTS_VH
// mode codes on {sel_a, sel_b, sel_c, sel_d}
`define PFP_MODE_LOCK       4'hA
`define PFP_MODE_UNLOCK     4'hB
`define PFP_MODE_PG_WRITE   4'h7
`define PFP_MODE_PG_LOAD    4'h5
`define PFP_MODE_VERIFY     4'h3
`define PFP_MODE_SEC_READ   4'h1
`define PFP_MODE_SEC_WRITE  4'hC
`define PFP_MODE_ERASE      4'h8
`define PFP_MODE_XR_WRITE   4'hD
`define PFP_MODE_XR_LOAD    4'hE
`define PFP_MODE_XR_READ    4'h0
`define PFP_UNLOCK_KEY1     8'h55
`define PFP_UNLOCK_KEY2     8'hAA
`define PFP_ERASED          8'hFF
`define PFP_UNLOCK_MIN_CLK  25
`define PFP_WRITE_TIME_NS   10000000
`define PFP_CLK_NS          10
`define PFP_XR_BOOT_STAT    7'h00
`define PFP_XR_BOOT_VEC     7'h01
`define PFP_XR_SEC_COPY     7'h04
`define PFP_XR_SW_SEC       7'h05
`define PFP_XR_BOOT_REF     7'h06
`define PFP_XR_MAKER        7'h30
`define PFP_XR_PART1        7'h31
`define PFP_XR_PART2        7'h60
`define PFP_XR_PART3        7'h61
`define PFP_RST_BOOT_STAT   8'hFF
`define PFP_RST_BOOT_VEC    8'hFC
`define PFP_RST_SEC_COPY    8'h18
`define PFP_RST_SW_SEC      8'hFF
`endif

// ---- verilog/pfp_fifo.v ----
// parameterised fifo between page-load capture and page buffer
`timescale 1ns/10ps
module pfp_fifo #(
  parameter WIDTH = 23,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;
  assign in_ready  = (cnt_r != DEPTH);
  assign out_valid = (cnt_r != 0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always @(posedge ref_clk) begin
    if (reset) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r        <= (wp_r == DEPTH-1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop)
        rp_r <= (rp_r == DEPTH-1) ? {AW{1'b0}} : rp_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // pfp_fifo

// ---- verilog/pfp_port.v ----
// parallel flash programming port: mode decode, unlock, page load/write, erase, verify
`timescale 1ns/10ps
`include "pfp_consts.vh"
module pfp_port #(
  parameter AW         = 16,
  parameter PAGE       = 128,
  parameter FIFO_DEPTH = 8,
  parameter WRITE_CLKS = (`PFP_WRITE_TIME_NS + `PFP_CLK_NS - 1) / `PFP_CLK_NS,
  parameter [7:0] MAKER_ID = 8'h11, // arbitrary identity value
  parameter [7:0] PART_ID1 = 8'h22, // arbitrary identity value
  parameter [7:0] PART_ID2 = 8'h33, // arbitrary identity value
  parameter [7:0] PART_ID3 = 8'h44  // arbitrary identity value
) (
  input  wire       ref_clk,
  input  wire       reset,
  input  wire [7:0] port1_in,
  input  wire [5:0] port2_addr_in,
  input  wire [1:0] port3_addr_in,
  input  wire       sel_a,
  input  wire       sel_b,
  input  wire       sel_c,
  input  wire       sel_d,
  input  wire       output_enable_line,
  input  wire       latch_program_strobe,
  input  wire [7:0] port0_in,
  output reg  [7:0] port0_out,
  output wire       port0_oe,
  output reg        ready_busy_line,
  output reg        access_unlocked
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_WRITE = 3'b010;
  localparam ST_ERASE = 3'b100;
  localparam FW = AW + 8 - 1;

  // ===========================================================
  // storage
  reg [7:0]  array_r [0:(1<<AW)-1];
  reg [7:0]  xrow_r  [0:PAGE-1];
  reg [7:0]  hsb_r;
  reg        pbuf_v_r [0:PAGE-1];
  reg [7:0]  pbuf_r   [0:PAGE-1];
  reg [AW-1:0] page_base_r;
  reg        xr_target_r;

  // ===========================================================
  // inputs: address, mode, strobe edges
  wire [AW-1:0] addr = {port3_addr_in, port2_addr_in, port1_in};
  wire [3:0]    mode = {sel_a, sel_b, sel_c, sel_d};
  reg           strobe_q_r;
  wire          strobe_rise = latch_program_strobe && !strobe_q_r;
  reg  [15:0]   low_cnt_r;
  reg  [1:0]    key_stage_r;
  reg  [2:0]    state_r;
  reg  [31:0]   busy_cnt_r;
  integer       i;

  // ===========================================================
  // page load capture through fifo
  wire          load_mode = (mode == `PFP_MODE_PG_LOAD) || (mode == `PFP_MODE_XR_LOAD);
  wire [FW:0]   f_out;
  wire          f_valid;
  wire          f_in_ready;
  wire          f_pop = f_valid && (state_r == ST_IDLE);
  pfp_fifo #(.WIDTH(FW+1), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_data   ({addr, port0_in}),
    .in_valid  (strobe_rise && load_mode),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_valid),
    .out_ready (state_r == ST_IDLE)
  );

  // ===========================================================
  // read data path
  reg [7:0] rd_byte;
  always @* begin
    case (mode)
      `PFP_MODE_VERIFY:   rd_byte = array_r[addr];
      `PFP_MODE_SEC_READ: rd_byte = hsb_r;
      `PFP_MODE_XR_READ:  rd_byte = xrow_r[port1_in[6:0]];
      default:            rd_byte = `PFP_ERASED;
    endcase
  end
  assign port0_oe = output_enable_line && (mode == `PFP_MODE_VERIFY || mode == `PFP_MODE_SEC_READ ||
                    mode == `PFP_MODE_XR_READ);

  // ===========================================================
  // control
  wire start_ok = access_unlocked && strobe_rise && (state_r == ST_IDLE) && !f_valid;
  always @(posedge ref_clk) begin
    if (reset) begin
      strobe_q_r      <= 1'b1; // idle level of the strobe, no false rise after reset
      low_cnt_r       <= 16'h0000;
      key_stage_r     <= 2'h0;
      access_unlocked <= 1'b0;
      state_r         <= ST_IDLE;
      busy_cnt_r      <= 32'h0000_0000;
      ready_busy_line <= 1'b1;
      port0_out       <= 8'h00;
      page_base_r     <= {AW{1'b0}};
      xr_target_r     <= 1'b0;
      hsb_r           <= `PFP_RST_SEC_COPY;
      for (i = 0; i < PAGE; i = i + 1) begin
        pbuf_v_r[i] <= 1'b0;
        xrow_r[i]   <= `PFP_ERASED;
      end
      xrow_r[`PFP_XR_BOOT_STAT] <= `PFP_RST_BOOT_STAT;
      xrow_r[`PFP_XR_BOOT_VEC]  <= `PFP_RST_BOOT_VEC;
      xrow_r[`PFP_XR_SEC_COPY]  <= `PFP_RST_SEC_COPY;
      xrow_r[`PFP_XR_SW_SEC]    <= `PFP_RST_SW_SEC;
      xrow_r[`PFP_XR_MAKER]     <= MAKER_ID;
      xrow_r[`PFP_XR_PART1]     <= PART_ID1;
      xrow_r[`PFP_XR_PART2]     <= PART_ID2;
      xrow_r[`PFP_XR_PART3]     <= PART_ID3;
    end else begin
      strobe_q_r <= latch_program_strobe;
      port0_out  <= rd_byte;
      low_cnt_r  <= latch_program_strobe ? 16'h0000 :
                    (low_cnt_r == 16'hFFFF ? low_cnt_r : low_cnt_r + 16'h0001);
      // unlock key sequence and lock
      if (mode == `PFP_MODE_LOCK) begin
        access_unlocked <= 1'b0;
        key_stage_r     <= 2'h0;
      end else if (mode == `PFP_MODE_UNLOCK && strobe_rise) begin
        if (low_cnt_r < `PFP_UNLOCK_MIN_CLK)
          key_stage_r <= 2'h0;
        else if (key_stage_r == 2'h0 && port0_in == `PFP_UNLOCK_KEY1)
          key_stage_r <= 2'h1;
        else if (key_stage_r == 2'h1 && port0_in == `PFP_UNLOCK_KEY2) begin
          key_stage_r     <= 2'h0;
          access_unlocked <= 1'b1;
        end else
          key_stage_r <= 2'h0;
      end else if (mode != `PFP_MODE_UNLOCK)
        key_stage_r <= 2'h0;
      // drain fifo into page buffer
      if (f_pop) begin
        pbuf_r[f_out[14:8]]   <= f_out[7:0];
        pbuf_v_r[f_out[14:8]] <= 1'b1;
        page_base_r           <= f_out[FW:8];
      end
      case (state_r)
        ST_IDLE: begin
          if (start_ok && (mode == `PFP_MODE_PG_WRITE || mode == `PFP_MODE_XR_WRITE)) begin
            state_r         <= ST_WRITE;
            xr_target_r     <= (mode == `PFP_MODE_XR_WRITE);
            ready_busy_line <= 1'b0;
            busy_cnt_r      <= WRITE_CLKS;
          end else if (start_ok && mode == `PFP_MODE_ERASE) begin
            state_r         <= ST_ERASE;
            ready_busy_line <= 1'b0;
            busy_cnt_r      <= WRITE_CLKS;
          end else if (start_ok && mode == `PFP_MODE_SEC_WRITE) begin
            hsb_r                    <= hsb_r & port0_in;
            xrow_r[`PFP_XR_SEC_COPY] <= hsb_r & port0_in;
            state_r                  <= ST_WRITE;
            ready_busy_line          <= 1'b0;
            busy_cnt_r               <= WRITE_CLKS;
          end
        end
        ST_WRITE: begin
          if (busy_cnt_r > 32'h0000_0001)
            busy_cnt_r <= busy_cnt_r - 32'h0000_0001;
          else begin
            for (i = 0; i < PAGE; i = i + 1) begin
              if (pbuf_v_r[i]) begin
                if (xr_target_r)
                  xrow_r[i] <= pbuf_r[i];
                else
                  array_r[{page_base_r[AW-1:7], i[6:0]}] <= pbuf_r[i];
              end
              pbuf_v_r[i] <= 1'b0;
            end
            state_r         <= ST_IDLE;
            ready_busy_line <= 1'b1;
          end
        end
        ST_ERASE: begin
          if (busy_cnt_r > 32'h0000_0001)
            busy_cnt_r <= busy_cnt_r - 32'h0000_0001;
          else begin
            for (i = 0; i < (1<<AW); i = i + 1)
              array_r[i] <= `PFP_ERASED;
            for (i = 0; i < PAGE; i = i + 1) begin
              xrow_r[i]   <= `PFP_ERASED;
              pbuf_v_r[i] <= 1'b0;
            end
            hsb_r           <= `PFP_ERASED;
            state_r         <= ST_IDLE;
            ready_busy_line <= 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // pfp_port

// ---- tb/pfp_sva.sv ----
// checker for the parallel flash programming port
`timescale 1ns/10ps
`include "pfp_consts.vh"
module pfp_sva #(
  parameter WRITE_CLKS = 20
) (
  input wire       ref_clk,
  input wire       reset,
  input wire       sel_a,
  input wire       sel_b,
  input wire       sel_c,
  input wire       sel_d,
  input wire       output_enable_line,
  input wire       latch_program_strobe,
  input wire [7:0] port0_in,
  input wire       port0_oe,
  input wire       ready_busy_line,
  input wire       access_unlocked
);
  wire [3:0]  mode = {sel_a, sel_b, sel_c, sel_d};
  reg  [31:0] busy_cnt_r;
  // counts sampled busy cycles of one operation
  always @(posedge ref_clk) busy_cnt_r <= (reset || ready_busy_line) ? 32'h0 : busy_cnt_r + 32'h1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_oe_needs_enable: assert property (port0_oe |-> output_enable_line) else $error("oe without enable");
  a_oe_verify_read: assert property (output_enable_line && mode == `PFP_MODE_VERIFY |-> port0_oe)
    else $error("verify not driven");
  a_reset_locks: assert property ($fell(reset) |-> !access_unlocked && ready_busy_line)
    else $error("not locked after reset");
  a_unlock_key_order: assert property ($rose(access_unlocked) |-> $past(port0_in) == `PFP_UNLOCK_KEY2
    && $past(mode) == `PFP_MODE_UNLOCK) else $error("unlock without keys");
  a_locked_no_op: assert property (!access_unlocked && ready_busy_line && $rose(latch_program_strobe)
    |=> ready_busy_line) else $error("locked op started");
  a_write_goes_busy: assert property ($rose(latch_program_strobe) && mode == `PFP_MODE_PG_WRITE
    && access_unlocked && ready_busy_line |=> !ready_busy_line) else $error("write not busy");
  a_busy_length: assert property ($rose(ready_busy_line) |-> busy_cnt_r == WRITE_CLKS)
    else $error("busy length wrong");
  a_busy_bounded: assert property ($fell(ready_busy_line) |-> ##[1:200] ready_busy_line)
    else $error("busy too long");
  a_lock_mode: assert property ($rose(latch_program_strobe) && mode == `PFP_MODE_LOCK
    |-> ##[1:2] !access_unlocked) else $error("lock ignored");
  c_unlock: cover property ($rose(access_unlocked));
  c_done: cover property ($rose(ready_busy_line));
  c_read: cover property (port0_oe);
endmodule // pfp_sva
bind pfp_port pfp_sva #(.WRITE_CLKS(WRITE_CLKS)) u_sva (.ref_clk(ref_clk), .reset(reset), .sel_a(sel_a),
  .sel_b(sel_b), .sel_c(sel_c), .sel_d(sel_d), .output_enable_line(output_enable_line),
  .latch_program_strobe(latch_program_strobe), .port0_in(port0_in), .port0_oe(port0_oe),
  .ready_busy_line(ready_busy_line), .access_unlocked(access_unlocked));

// ---- tb/pfp_prog.sv ----
// model of the external parallel programmer
`timescale 1ns/10ps
`include "pfp_consts.vh"
module pfp_prog (
  input  wire       ref_clk,
  output reg  [7:0] port1_in,
  output reg  [5:0] port2_addr_in,
  output reg  [1:0] port3_addr_in,
  output reg        sel_a,
  output reg        sel_b,
  output reg        sel_c,
  output reg        sel_d,
  output reg        output_enable_line,
  output reg        latch_program_strobe,
  output reg  [7:0] port0_in
);
  initial begin
    {port3_addr_in, port2_addr_in, port1_in} = 16'h0000;
    {sel_a, sel_b, sel_c, sel_d} = `PFP_MODE_XR_READ;
    output_enable_line = 1'b0;
    latch_program_strobe = 1'b1;
    port0_in = 8'h00;
  end
  task set(input [3:0] m, input [15:0] a, input oe);
    begin
      @(posedge ref_clk);
      #1;
      {sel_a, sel_b, sel_c, sel_d} = m;
      {port3_addr_in, port2_addr_in, port1_in} = a;
      output_enable_line = oe;
    end
  endtask
  task pulse(input [7:0] d, input integer n);
    integer i;
    begin
      @(posedge ref_clk);
      #1;
      port0_in = d;
      latch_program_strobe = 1'b0;
      for (i = 0; i < n; i = i + 1) @(posedge ref_clk);
      #1 latch_program_strobe = 1'b1;
      repeat (2) @(posedge ref_clk);
      // released data lines no longer show the last byte
      #1 port0_in = ~d;
    end
  endtask
  task unlock(input integer n);
    begin
      set(`PFP_MODE_UNLOCK, 16'h0000, 1'b0);
      pulse(`PFP_UNLOCK_KEY1, n);
      pulse(`PFP_UNLOCK_KEY2, n);
    end
  endtask
endmodule // pfp_prog

// ---- tb/tb_top.sv ----
// testbench for the parallel flash programming port
`timescale 1ns/10ps
`include "pfp_consts.vh"
`define CK(nm, e, g) begin checks = checks + 1; if ((g) !== (e)) begin n_errors = n_errors + 1; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  reg        ref_clk = 1'b0;
  reg        reset = 1'b1;
  integer    n_errors = 0;
  integer    checks = 0;
  localparam [7:0] ID_M    = 8'h3C;
  localparam [7:0] ID_P1   = 8'h4D;
  localparam [7:0] ID_P2   = 8'h5E;
  localparam [7:0] ID_P3   = 8'h6F;
  localparam       WR_CLKS = 20;
  wire [7:0] p1, p0i, p0o;
  wire [5:0] p2;
  wire [1:0] p3;
  wire       sa, sb, sc, sd, oe_en, stb, oe, rdy, unl;
  always #5 ref_clk = ~ref_clk;
  pfp_prog PRG (.ref_clk(ref_clk), .port1_in(p1), .port2_addr_in(p2), .port3_addr_in(p3), .sel_a(sa),
    .sel_b(sb), .sel_c(sc), .sel_d(sd), .output_enable_line(oe_en), .latch_program_strobe(stb), .port0_in(p0i));
  pfp_port #(.WRITE_CLKS(WR_CLKS), .MAKER_ID(ID_M), .PART_ID1(ID_P1), .PART_ID2(ID_P2), .PART_ID3(ID_P3)) DUT (
    .ref_clk(ref_clk), .reset(reset), .port1_in(p1), .port2_addr_in(p2), .port3_addr_in(p3), .sel_a(sa),
    .sel_b(sb), .sel_c(sc), .sel_d(sd), .output_enable_line(oe_en), .latch_program_strobe(stb),
    .port0_in(p0i), .port0_out(p0o), .port0_oe(oe), .ready_busy_line(rdy), .access_unlocked(unl));
  task final_report;
    begin
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task rd(input [3:0] m, input [15:0] a, input [7:0] e);
    begin
      PRG.set(m, a, 1'b1);
      repeat (2) @(posedge ref_clk);
      #1;
      `CK("port0_out", e, p0o)
      `CK("port0_oe", 1'b1, oe)
    end
  endtask
  task op(input [3:0] m, input [15:0] a, input integer i);
    begin
      PRG.unlock(26);
      PRG.set(m, a, 1'b0);
      PRG.pulse(8'h00, 2);
      `CK("busy", 1'b0, rdy)
      i = 0;
      while (rdy !== 1'b1 && i < 100) begin
        @(posedge ref_clk);
        #1 i = i + 1;
      end
      `CK("ready", 1'b1, rdy)
      `CK("busy_len", WR_CLKS - 1, i)
    end
  endtask
  task t_defaults;
    begin
      rd(`PFP_MODE_XR_READ, 16'h0004, `PFP_RST_SEC_COPY);
      rd(`PFP_MODE_XR_READ, 16'h0005, `PFP_RST_SW_SEC);
      rd(`PFP_MODE_XR_READ, 16'h0000, `PFP_RST_BOOT_STAT);
      rd(`PFP_MODE_XR_READ, 16'h0001, `PFP_RST_BOOT_VEC);
      rd(`PFP_MODE_XR_READ, 16'h0030, ID_M);
      rd(`PFP_MODE_XR_READ, 16'h0031, ID_P1);
      rd(`PFP_MODE_XR_READ, 16'h0060, ID_P2);
      rd(`PFP_MODE_XR_READ, 16'h0061, ID_P3);
      rd(`PFP_MODE_SEC_READ, 16'h0000, `PFP_RST_SEC_COPY);
      PRG.set(`PFP_MODE_VERIFY, 16'h0000, 1'b0);
      #1 `CK("oe_off", 1'b0, oe)
    end
  endtask
  task t_locked;
    begin
      PRG.set(`PFP_MODE_ERASE, 16'h0000, 1'b0);
      PRG.pulse(8'h00, 26);
      `CK("locked_ready", 1'b1, rdy)
      `CK("locked", 1'b0, unl)
      PRG.unlock(10);
      `CK("short_unlock", 1'b0, unl)
      PRG.unlock(26);
      `CK("unlocked", 1'b1, unl)
    end
  endtask
  task t_program;
    begin
      PRG.set(`PFP_MODE_PG_LOAD, 16'hC080, 1'b0);
      PRG.pulse(8'hA5, 2);
      PRG.set(`PFP_MODE_PG_LOAD, 16'hC0FF, 1'b0);
      PRG.pulse(8'h3C, 2);
      op(`PFP_MODE_PG_WRITE, 16'hC080, 0);
      rd(`PFP_MODE_VERIFY, 16'hC080, 8'hA5);
      rd(`PFP_MODE_VERIFY, 16'hC0FF, 8'h3C);
    end
  endtask
  task t_xrow;
    begin
      PRG.set(`PFP_MODE_XR_LOAD, 16'h0006, 1'b0);
      PRG.pulse(8'h5A, 2);
      op(`PFP_MODE_XR_WRITE, 16'h0006, 0);
      rd(`PFP_MODE_XR_READ, 16'h0006, 8'h5A);
      op(`PFP_MODE_SEC_WRITE, 16'h0000, 0);
      rd(`PFP_MODE_SEC_READ, 16'h0000, 8'h00);
      rd(`PFP_MODE_XR_READ, 16'h0004, 8'h00);
    end
  endtask
  task t_erase;
    begin
      op(`PFP_MODE_ERASE, 16'h0000, 0);
      rd(`PFP_MODE_VERIFY, 16'hC080, `PFP_ERASED);
      rd(`PFP_MODE_XR_READ, 16'h0004, `PFP_ERASED);
      PRG.set(`PFP_MODE_LOCK, 16'h0000, 1'b0);
      PRG.pulse(8'h00, 2);
      `CK("relocked", 1'b0, unl)
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 reset = 1'b0;
    t_defaults;
    t_locked;
    t_program;
    t_xrow;
    t_erase;
    final_report;
  end
  initial begin
    #200000;
    n_errors = n_errors + 1;
    final_report;
  end
endmodule // tb_top
